// *** logic/olp_pkg.sv ***
package olp_pkg;
	// base timings at 40 MHz
	localparam int unsigned CLK_HZ              = 40_000_000;
	localparam int unsigned BLANK_TIME_MS       = 20;   // overload_blank_time
	localparam int unsigned BLANK_CYCLES        = BLANK_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned RECOVERY_TIME_MS    = 20;   // fault_recovery_timeout, plain default
	localparam int unsigned RECOVERY_CYCLES     = RECOVERY_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned SETTLE_TIME_MS      = 1;    // sense_settle_blank_time, plain default
	localparam int unsigned SETTLE_CYCLES       = SETTLE_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned SOFTSTART_TIME_MS   = 32;   // soft start duration
	localparam int unsigned SOFTSTART_CYCLES    = SOFTSTART_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned EXT_COUNT_DEF       = 8;    // extended_blank_count, plain default
	localparam int unsigned RESTART_COUNT_DEF   = 8;    // restart_cycle_count, plain default
	localparam int unsigned TIMER_W             = 24;
	localparam int unsigned COUNT_W             = 8;

	// sequencer states
	typedef enum logic [3:0] {
		OLP_SOFTSTART,
		OLP_NORMAL,
		OLP_EXT_DISCH,
		OLP_EXT_CHARGE,
		OLP_PULL_ZERO,
		OLP_WAIT_FINAL,
		OLP_PROT_DISCH,
		OLP_PROT_CHARGE,
		OLP_PROT_SDISCH,
		OLP_SETTLE,
		OLP_WAIT_INPUT
	} olp_state_e;
endpackage : olp_pkg

// *** logic/olp_sync.sv ***
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages 1 and 2 agree
module olp_sync (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic async_in,
	output logic      sync_out
);
	logic [2:0] stage_q;  // stage 0 only feeds stage 1

	// shift chain
	always_ff @(posedge clk) begin
		if (reset) begin
			stage_q <= 3'h0;
		end else begin
			stage_q <= {stage_q[1:0], async_in};
		end
	end

	// filtered level, updates only on agreement
	always_ff @(posedge clk) begin
		if (reset) begin
			sync_out <= 1'b0;
		end else if (stage_q[1] == stage_q[2]) begin
			sync_out <= stage_q[2];
		end
	end
endmodule : olp_sync

// *** logic/olp_seq.sv ***
`timescale 1ns/1ps
module olp_seq #(
	parameter int unsigned EXT_COUNT     = olp_pkg::EXT_COUNT_DEF,
	parameter int unsigned RESTART_COUNT = olp_pkg::RESTART_COUNT_DEF,
	parameter int unsigned BLANK_CYC     = olp_pkg::BLANK_CYCLES,
	parameter int unsigned RECOVERY_CYC  = olp_pkg::RECOVERY_CYCLES,
	parameter int unsigned SETTLE_CYC    = olp_pkg::SETTLE_CYCLES,
	parameter int unsigned SOFTSTART_CYC = olp_pkg::SOFTSTART_CYCLES
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic fb_above_high,           // feedback_pin above feedback_high_threshold
	input  wire logic fb_below_low,            // feedback_pin at/below feedback_low_threshold
	input  wire logic fb_at_zero,              // feedback_pin pulled to ground
	input  wire logic sense_above_high,        // input_sense_pin above sense_high_threshold
	input  wire logic sense_below_low,         // input_sense_pin at/below sense_low_threshold
	input  wire logic sense_above_on,          // input_sense_pin above input_on_threshold
	output logic      feedback_discharge_switch,
	output logic      sense_discharge_switch,
	output logic      sense_charge_source,
	output logic      hysteresis_source_en,
	output logic      gate_enable,             // both high- and low-side gates
	output logic      min_freq_only,           // oscillator uses minimum charge current only
	output logic      soft_start_active,
	output logic      overload_protection_state
);
	import olp_pkg::*;

	localparam logic [TIMER_W-1:0] BLANK_LAST    = TIMER_W'(BLANK_CYC - 1);
	localparam logic [TIMER_W-1:0] RECOV_LAST    = TIMER_W'(RECOVERY_CYC - 1);
	localparam logic [TIMER_W-1:0] SETTLE_LAST   = TIMER_W'(SETTLE_CYC - 1);
	localparam logic [TIMER_W-1:0] SS_LAST       = TIMER_W'(SOFTSTART_CYC - 1);
	localparam logic [COUNT_W-1:0] EXT_LAST      = COUNT_W'(EXT_COUNT - 1);
	localparam logic [COUNT_W-1:0] RESTART_LAST  = COUNT_W'(RESTART_COUNT - 1);

	// synchronised comparator levels
	logic fbh_s;    // feedback high
	logic fbl_s;    // feedback low
	logic fbz_s;    // feedback zero
	logic snh_s;    // sense high
	logic snl_s;    // sense low
	logic snon_s;   // sense above turn-on

	olp_sync u_sync_fbh  (.clk(clk), .reset(reset), .async_in(fb_above_high),
		.sync_out(fbh_s));
	olp_sync u_sync_fbl  (.clk(clk), .reset(reset), .async_in(fb_below_low),     .sync_out(fbl_s));
	olp_sync u_sync_fbz  (.clk(clk), .reset(reset), .async_in(fb_at_zero),       .sync_out(fbz_s));
	olp_sync u_sync_snh  (.clk(clk), .reset(reset), .async_in(sense_above_high), .sync_out(snh_s));
	olp_sync u_sync_snl  (.clk(clk), .reset(reset), .async_in(sense_below_low),  .sync_out(snl_s));
	olp_sync u_sync_snon (.clk(clk), .reset(reset), .async_in(sense_above_on),   .sync_out(snon_s));

	olp_state_e         state_q;      // sequencer state
	olp_state_e         state_d;
	logic [TIMER_W-1:0] timer_q;      // shared blanking / recovery timer
	logic [TIMER_W-1:0] timer_d;
	logic [COUNT_W-1:0] count_q;      // fault / restart cycle counter
	logic [COUNT_W-1:0] count_d;

	// timer and counter end flags
	wire blank_done  = (timer_q == BLANK_LAST);
	wire recov_done  = (timer_q == RECOV_LAST);
	wire settle_done = (timer_q == SETTLE_LAST);
	wire ss_done     = (timer_q == SS_LAST);
	wire ext_final   = (count_q == EXT_LAST);
	wire rst_final   = (count_q == RESTART_LAST);
	wire timer_inc   = ~&timer_q;     // saturate rather than wrap

	// next-state logic
	always_comb begin
		state_d = state_q;
		timer_d = timer_inc ? timer_q + TIMER_W'(1) : timer_q;
		count_d = count_q;
		unique case (state_q)
			OLP_SOFTSTART: begin
				// feedback high is ignored here; only the ramp timer runs
				if (ss_done) begin
					state_d = OLP_NORMAL;
					timer_d = '0;
				end
			end
			OLP_NORMAL: begin
				// timer counts only while feedback stays high continuously
				if (!fbh_s) begin
					timer_d = '0;
				end else if (blank_done) begin
					state_d = OLP_EXT_DISCH;
					timer_d = '0;
					count_d = '0;
				end
			end
			OLP_EXT_DISCH: begin
				if (fbl_s) begin
					state_d = OLP_EXT_CHARGE;
				end
			end
			OLP_EXT_CHARGE: begin
				if (fbh_s) begin
					count_d = count_q + COUNT_W'(1);
					state_d = ext_final ? OLP_PULL_ZERO : OLP_EXT_DISCH;
				end
			end
			OLP_PULL_ZERO: begin
				if (fbz_s) begin
					state_d = OLP_WAIT_FINAL;
					timer_d = '0;
				end
			end
			OLP_WAIT_FINAL: begin
				if (fbh_s) begin
					state_d = OLP_PROT_DISCH;
					count_d = '0;
				end else if (recov_done) begin
					state_d = OLP_NORMAL;
					timer_d = '0;
					count_d = '0;
				end
			end
			OLP_PROT_DISCH: begin
				if (snl_s) begin
					state_d = OLP_PROT_CHARGE;
				end
			end
			OLP_PROT_CHARGE: begin
				if (snh_s) begin
					state_d = OLP_PROT_SDISCH;
				end
			end
			OLP_PROT_SDISCH: begin
				if (snl_s) begin
					count_d = count_q + COUNT_W'(1);
					if (rst_final) begin
						state_d = OLP_SETTLE;
						timer_d = '0;
					end else begin
						state_d = OLP_PROT_CHARGE;
					end
				end
			end
			OLP_SETTLE: begin
				if (settle_done) begin
					state_d = OLP_WAIT_INPUT;
				end
			end
			OLP_WAIT_INPUT: begin
				// hold off until mains is in range, then restart
				if (snon_s) begin
					state_d = OLP_SOFTSTART;
					timer_d = '0;
					count_d = '0;
				end
			end
		endcase
	end

	// decoded outputs, registered below
	wire in_ext   = (state_q == OLP_EXT_DISCH) || (state_q == OLP_EXT_CHARGE) ||
	                (state_q == OLP_PULL_ZERO) || (state_q == OLP_WAIT_FINAL);
	wire in_prot  = (state_q == OLP_PROT_DISCH) || (state_q == OLP_PROT_CHARGE) ||
	                (state_q == OLP_PROT_SDISCH) || (state_q == OLP_SETTLE) ||
	                (state_q == OLP_WAIT_INPUT);
	wire fb_dis_d = (state_q == OLP_EXT_DISCH) || (state_q == OLP_PULL_ZERO);
	wire sn_dis_d = (state_q == OLP_PROT_DISCH) || (state_q == OLP_PROT_SDISCH);
	wire sn_chg_d = (state_q == OLP_PROT_CHARGE);
	// hysteresis source is off only while the sense pin is used as a timer
	wire hys_d    = !((state_q == OLP_PROT_DISCH) || (state_q == OLP_PROT_CHARGE) ||
	                  (state_q == OLP_PROT_SDISCH));

	// state registers
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= OLP_SOFTSTART;
			timer_q <= '0;
			count_q <= '0;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			count_q <= count_d;
		end
	end

	// output flops; they lag the state by one cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			feedback_discharge_switch <= 1'b0;
			sense_discharge_switch    <= 1'b0;
			sense_charge_source       <= 1'b0;
			hysteresis_source_en      <= 1'b1;
			gate_enable               <= 1'b0;
			min_freq_only             <= 1'b0;
			soft_start_active         <= 1'b0;
			overload_protection_state <= 1'b0;
		end else begin
			feedback_discharge_switch <= fb_dis_d;
			sense_discharge_switch    <= sn_dis_d;
			sense_charge_source       <= sn_chg_d;
			hysteresis_source_en      <= hys_d;
			gate_enable               <= !in_prot;
			min_freq_only             <= in_ext;
			soft_start_active         <= (state_q == OLP_SOFTSTART);
			overload_protection_state <= in_prot;
		end
	end
endmodule : olp_seq

// *** sim/olp_rc_model.sv ***
`timescale 1ns/1ps
// rc networks on the feedback and input-sense pins, as levels 0..100
module olp_rc_model (
	input  wire logic clk,
	input  wire logic fault,            // open loop: feedback climbs to the top
	input  wire logic bus_ok,           // mains inside its range
	input  wire logic fb_dis,           // feedback discharge switch
	input  wire logic s_chg,            // sense charge source
	input  wire logic s_dis,            // sense discharge switch
	output logic      fb_above_high,
	output logic      fb_below_low,
	output logic      fb_at_zero,
	output logic      sense_above_high,
	output logic      sense_below_low,
	output logic      sense_above_on
);
	int fb = 50;  // feedback level
	int sn = 70;  // sense level
	// slow steps, so the sequencer lag cannot skip past a threshold
	always @(posedge clk) begin
		if (fb_dis) fb <= (fb > 0) ? fb - 1 : 0;
		else if (fault) fb <= (fb < 100) ? fb + 2 : 100;
		else fb <= fb + ((fb < 50) ? 1 : (fb > 50) ? -1 : 0);
		if (s_dis) sn <= (sn > 4) ? sn - 4 : 0;
		else if (s_chg) sn <= (sn < 100) ? sn + 2 : 100;
		else sn <= sn + ((sn < (bus_ok ? 70 : 20)) ? 1 : (sn > (bus_ok ? 70 : 20)) ? -1 : 0);
	end
	// comparators of the pins
	assign fb_above_high    = (fb >= 80);
	assign fb_below_low     = (fb <= 10);
	assign fb_at_zero       = (fb == 0);
	assign sense_above_high = (sn >= 80);
	assign sense_below_low  = (sn <= 20);
	assign sense_above_on   = (sn >= 50);
endmodule : olp_rc_model

// *** sim/olp_seq_checker.sv ***
`timescale 1ns/1ps
// watches the sequencer ports for the order of the protection phases
module olp_seq_checker #(
	parameter int unsigned BLANK_CYC = 50
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic fb_above_high,
	input wire logic fb_below_low,
	input wire logic fb_at_zero,
	input wire logic sense_above_high,
	input wire logic sense_below_low,
	input wire logic sense_above_on,
	input wire logic feedback_discharge_switch,
	input wire logic sense_discharge_switch,
	input wire logic sense_charge_source,
	input wire logic hysteresis_source_en,
	input wire logic gate_enable,
	input wire logic min_freq_only,
	input wire logic soft_start_active,
	input wire logic overload_protection_state
);
	int unsigned hi_q;  // unbroken run of feedback high
	// saturating, so a stuck comparator cannot wrap it
	always_ff @(posedge clk) begin
		if (reset || !fb_above_high) hi_q <= 0;
		else if (hi_q < 1000000) hi_q <= hi_q + 1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence prot_start; $rose(overload_protection_state); endsequence
	sequence sense_idle; !sense_charge_source && !sense_discharge_switch; endsequence
	// a sequence cannot be negated, so the busy case gets its own name
	sequence sense_busy; sense_charge_source || sense_discharge_switch; endsequence
	chk_gate_prot: assert property (overload_protection_state |-> !gate_enable)
		else $error("gates on in protection");
	chk_ss_quiet: assert property (soft_start_active |->
		!min_freq_only && !feedback_discharge_switch)
		else $error("blanking during soft start");
	chk_blank_time: assert property ($rose(min_freq_only) |->
		feedback_discharge_switch && hi_q >= BLANK_CYC)
		else $error("blanking began early");
	chk_sense_excl: assert property (!(sense_charge_source && sense_discharge_switch))
		else $error("sense charge and discharge together");
	chk_charge_stop: assert property ($rose(sense_above_high) && sense_charge_source |->
		##[1:8] !sense_charge_source)
		else $error("sense charge not stopped");
	chk_prot_entry: assert property (prot_start |->
		sense_discharge_switch && !sense_charge_source)
		else $error("sense not discharged at entry");
	chk_prot_exit: assert property ($fell(overload_protection_state) |-> sense_idle)
		else $error("sense switches on after restart");
	chk_hyst_off: assert property (sense_busy |-> !hysteresis_source_en)
		else $error("hysteresis on while cycling");
endmodule : olp_seq_checker
bind olp_seq olp_seq_checker #(.BLANK_CYC(BLANK_CYC)) u_chk (.clk(clk), .reset(reset),
	.fb_above_high(fb_above_high), .fb_below_low(fb_below_low), .fb_at_zero(fb_at_zero),
	.sense_above_high(sense_above_high), .sense_below_low(sense_below_low),
	.sense_above_on(sense_above_on), .feedback_discharge_switch(feedback_discharge_switch),
	.sense_discharge_switch(sense_discharge_switch), .sense_charge_source(sense_charge_source),
	.hysteresis_source_en(hysteresis_source_en), .gate_enable(gate_enable),
	.min_freq_only(min_freq_only), .soft_start_active(soft_start_active),
	.overload_protection_state(overload_protection_state));

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %0t %s", $time, m); end end
// bench for the overload sequencer against the rc network models
module testbench;
	localparam int unsigned EXT_N = 2;  // short extended blanking count
	localparam int unsigned RST_N = 2;  // short restart count
	logic clk = 0, reset = 1, fault = 0, bus_ok = 1, p = 0;
	logic fb_hi, fb_lo, fb_z, s_hi, s_lo, s_on, fb_dis, s_dis, s_chg, hys, gate, minf, ss, prot;
	int n_fail = 0, total_checks = 0, i, n;
	always #12.5 clk = ~clk;  // 40 MHz
	olp_seq #(.EXT_COUNT(EXT_N), .RESTART_COUNT(RST_N), .BLANK_CYC(50), .RECOVERY_CYC(50),
		.SETTLE_CYC(20), .SOFTSTART_CYC(30)) DUT (.clk(clk), .reset(reset),
		.fb_above_high(fb_hi), .fb_below_low(fb_lo), .fb_at_zero(fb_z), .sense_above_high(s_hi),
		.sense_below_low(s_lo), .sense_above_on(s_on), .feedback_discharge_switch(fb_dis),
		.sense_discharge_switch(s_dis), .sense_charge_source(s_chg), .hysteresis_source_en(hys),
		.gate_enable(gate), .min_freq_only(minf), .soft_start_active(ss),
		.overload_protection_state(prot));
	olp_rc_model M (.clk(clk), .fault(fault), .bus_ok(bus_ok), .fb_dis(fb_dis), .s_chg(s_chg),
		.s_dis(s_dis), .fb_above_high(fb_hi), .fb_below_low(fb_lo), .fb_at_zero(fb_z),
		.sense_above_high(s_hi), .sense_below_low(s_lo), .sense_above_on(s_on));
	// samples after the edge's updates have landed
	task tick; @(posedge clk); #1; endtask : tick
	// reset values, soft start ignoring a stuck-high feedback, then blanking
	task t_start;
		repeat (2) @(posedge clk);
		#1 `CHK({gate, hys, prot, minf}, 4'h4, "reset outputs")
		@(posedge clk) reset <= 0;
		for (i = 0; i < 20 && !ss; i++) tick;
		`CHK(ss, 1'b1, "no soft start")
		@(posedge clk) fault <= 1;
		for (i = 0; i < 200 && ss; i++) tick;
		`CHK(minf, 1'b0, "feedback high not ignored")
		for (n = 0; n < 300 && !minf; n++) tick;
		`CHK(n >= 50 && n < 70, 1'b1, "blanking time")
		`CHK(fb_dis, 1'b1, "no feedback discharge")
	endtask : t_start
	// count the recharges, then drop the fault so recovery runs out
	task t_recover;
		n = 0;
		p = fb_hi;  // feedback still high from the blanking run; count fresh rises only
		for (i = 0; i < 3000 && !fb_z; i++) begin tick; n += (fb_hi && !p); p = fb_hi; end
		`CHK(fb_z, 1'b1, "no pull to zero")
		`CHK(n, EXT_N, "recharge count")
		`CHK(minf, 1'b1, "minimum frequency")
		@(posedge clk) fault <= 0;
		for (i = 0; i < 200 && minf; i++) tick;
		`CHK({minf, prot, gate}, 3'h1, "no return to normal")
	endtask : t_recover
	// full protection, restart cycle count, input too low and then in range
	task t_protect;
		@(posedge clk) fault <= 1;
		for (i = 0; i < 3000 && !prot; i++) tick;
		`CHK({prot, gate}, 2'h2, "no protection")
		@(posedge clk) fault <= 0;
		bus_ok <= 0;
		n = 0;
		p = s_chg;
		for (i = 0; i < 3000 && !hys; i++) begin tick; n += (s_chg && !p); p = s_chg; end
		`CHK(n, RST_N, "restart cycles")
		`CHK({hys, s_chg, s_dis}, 3'h4, "sense switches")
		repeat (60) tick;
		`CHK(ss, 1'b0, "soft start with input low")
		@(posedge clk) bus_ok <= 1;
		for (i = 0; i < 300 && !ss; i++) tick;
		`CHK({ss, gate}, 2'h3, "no restart")
	endtask : t_protect
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// main sequence
	initial begin
		t_start;
		t_recover;
		t_protect;
		end_of_test;
	end
	// watchdog, well past the sum of all waits
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_of_test;
	end
endmodule : testbench
